// ### shared/psc_pkg.sv
// What this block does
// - Latch all strap settings at every reset.
// - All address straps mode 1 give address zero.
// - Strap mode pairs decode to nine fixed addresses.
// - Error strap mode sets address bits 1 and 3.
// - Three strap bits select the host interface.
// - All-zero interface code reserved without SGMII variant.
// - Role strap 0 slave, 1 master.
// - Self-link strap 1 holds link until software release.
// - Writing 0 to hold bit releases link-up.
// - Clock-pin strap swaps clock and second indicator pins.
// - Indicator active level follows its own sampled strap.
// - Three indicators, functions chosen by indicator register.
package psc_pkg;

   // ===================================================
   // Timing
   localparam int CLK_PERIOD_NS = 25;
   localparam int STRAP_SETTLE_NS = 1000;
   localparam int STRAP_SETTLE_CYCLES = (STRAP_SETTLE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

   // ===================================================
   // Register port and map
   localparam int REG_ADDR_W = 16;
   localparam int REG_DATA_W = 16;
   localparam logic [15:0] REG_RESTART = 16'h001f;
   localparam logic [15:0] REG_LINK_CTRL = 16'h018b;
   localparam logic [15:0] REG_LED_CFG = 16'h0450;
   localparam logic [15:0] REG_STRAP_STATUS = 16'h0470;
   localparam int RESTART_BIT = 15;
   localparam int LINK_HOLD_BIT = 6;
   localparam logic [15:0] LED_CFG_RESET = 16'h0510;

   // Indicator configuration fields, four bits each
   localparam int LED_SEL_W = 4;
   localparam int LED0_SEL_POS = 0;
   localparam int LED1_SEL_POS = 4;
   localparam int LED2_SEL_POS = 8;

   // Strap status word layout
   localparam int ST_ADDR_POS = 0;
   localparam int ST_HOSTIF_POS = 5;
   localparam int ST_ROLE_POS = 8;
   localparam int ST_MANAGED_POS = 9;
   localparam int ST_CLKPIN_POS = 10;
   localparam int ST_POL0_POS = 11;
   localparam int ST_POL6_POS = 12;
   localparam int ST_POL16_POS = 13;
   localparam int ST_RESERVED_POS = 14;

   // ===================================================
   // Encodings
   localparam logic [1:0] STRAP_MODE1 = 2'h0;
   localparam logic [1:0] STRAP_MODE2 = 2'h1;
   localparam logic [1:0] STRAP_MODE3 = 2'h2;
   localparam logic [2:0] HOST_IF_SGMII = 3'h0;
   localparam int ADDR_W = 5;

   typedef enum logic [3:0] {
      PSC_LED_LINK = 4'h0,
      PSC_LED_ACT = 4'h1,
      PSC_LED_LINK_ACT = 4'h2,
      PSC_LED_OFF = 4'h3,
      PSC_LED_ON = 4'h4,
      PSC_LED_CLOCK = 4'h5
   } psc_led_sel_t;

   typedef enum logic [0:0] {
      PSC_SETTLE = 1'b0,
      PSC_RUN = 1'b1
   } psc_state_t;

endpackage

// ### rtl/psc_level_sync.sv
module psc_level_sync #(
   parameter int WIDTH = 1
) (
   // Clock and reset
   input wire logic clk,
   input wire logic sys_rst,
   // Pin levels in and out
   input wire logic [WIDTH-1:0] pinLevel,
   output logic [WIDTH-1:0] syncLevel
);

   logic [WIDTH-1:0] stage1_reg;

   // First stage feeds the second stage only
   always_ff @(posedge clk)
   begin
      if (sys_rst)
      begin
         stage1_reg <= '0;
         syncLevel <= '0;
      end
      else
      begin
         stage1_reg <= pinLevel;
         syncLevel <= stage1_reg;
      end
   end

endmodule

// ### rtl/psc_strap_latch.sv
module psc_strap_latch #(
   parameter bit HAS_SGMII = 1'b1,
   parameter int SETTLE_CYCLES = psc_pkg::STRAP_SETTLE_CYCLES
) (
   // Clock and reset
   input wire logic clk,
   input wire logic sys_rst,
   // Register port
   input wire logic [psc_pkg::REG_ADDR_W-1:0] regAddr,
   input wire logic [psc_pkg::REG_DATA_W-1:0] regWrData,
   input wire logic regWrEn,
   input wire logic regRdEn,
   output logic [psc_pkg::REG_DATA_W-1:0] regRdData,
   // Three-level address straps, mode code per pin
   input wire logic [1:0] rxCtrlStrap,
   input wire logic [1:0] rxErrorStrap,
   // Two-level straps on receive data pins
   input wire logic [2:0] hostInterfaceStrap,
   input wire logic rxData3Strap,
   // Shared indicator and clock pins
   input wire logic indicator0PinIn,
   output logic indicator0PinOut,
   output logic indicator0PinOe,
   input wire logic indicator1PinIn,
   output logic indicator1PinOut,
   output logic indicator1PinOe,
   input wire logic clockOutputPinIn,
   output logic clockOutputPinOut,
   output logic clockOutputPinOe,
   // Link status from the rest of the device
   input wire logic linkUp,
   input wire logic linkActivity,
   // Latched configuration
   output logic [psc_pkg::ADDR_W-1:0] mgmtAddressBits,
   output logic [2:0] hostInterfaceSelect,
   output logic hostInterfaceReserved,
   output logic masterSlaveRole,
   output logic clockPinSelect,
   output logic linkStartEnable,
   output logic strapsValid
);

   localparam int CNT_W = $clog2(SETTLE_CYCLES + 1);
   localparam logic [CNT_W-1:0] SETTLE_LAST = CNT_W'(SETTLE_CYCLES - 1);

   // ===================================================
   // Functions
   // Mode to {high bit, low bit} of an address pair; illegal code reads as mode 1
   function automatic logic [1:0] modeToBits(input logic [1:0] mode);
      logic [1:0] bits;
      bits = 2'h0;
      if (mode == psc_pkg::STRAP_MODE2)
         bits = 2'h2;
      else if (mode == psc_pkg::STRAP_MODE3)
         bits = 2'h3;
      return bits;
   endfunction

   // Level for one pin; polarity inverts indicator drive but never the clock
   function automatic logic pinDrive(input logic [3:0] sel, input logic pol,
                                     input logic link, input logic act,
                                     input logic clkTog);
      logic on;
      on = 1'b0;
      unique case (psc_pkg::psc_led_sel_t'(sel))
         psc_pkg::PSC_LED_LINK: on = link;
         psc_pkg::PSC_LED_ACT: on = act;
         psc_pkg::PSC_LED_LINK_ACT: on = link | act;
         psc_pkg::PSC_LED_OFF: on = 1'b0;
         psc_pkg::PSC_LED_ON: on = 1'b1;
         psc_pkg::PSC_LED_CLOCK: on = clkTog;
         default: on = 1'b0;
      endcase
      return (sel == psc_pkg::PSC_LED_CLOCK) ? on : (on ^ pol);
   endfunction

   // ===================================================
   // Pin synchronisers
   logic [10:0] syncVec;
   logic [1:0] sCtrl;
   logic [1:0] sErr;
   logic [2:0] sHostIf;
   logic sRxD3;
   logic sPin0;
   logic sPin6;
   logic sPin16;

   psc_level_sync #(
      .WIDTH(11)
   ) u_sync (
      .clk(clk),
      .sys_rst(sys_rst),
      .pinLevel({rxCtrlStrap, rxErrorStrap, hostInterfaceStrap, rxData3Strap,
                 indicator0PinIn, indicator1PinIn, clockOutputPinIn}),
      .syncLevel(syncVec)
   );

   assign sCtrl = syncVec[10:9];
   assign sErr = syncVec[8:7];
   assign sHostIf = syncVec[6:4];
   assign sRxD3 = syncVec[3];
   assign sPin0 = syncVec[2];
   assign sPin6 = syncVec[1];
   assign sPin16 = syncVec[0];

   // ===================================================
   // Strap decode
   logic [1:0] ctrlBits;
   logic [1:0] errBits;
   logic [psc_pkg::ADDR_W-1:0] addrDecoded;
   logic managedStrap;
   logic reservedCode;

   assign ctrlBits = modeToBits(sCtrl);
   assign errBits = modeToBits(sErr);
   // Both straps in mode 1 fall out as address zero
   assign addrDecoded = {1'b0, errBits[1], ctrlBits[1], errBits[0], ctrlBits[0]};
   // Self-link strap follows the pin that carries the second indicator
   assign managedStrap = sRxD3 ? sPin16 : sPin6;
   assign reservedCode = !HAS_SGMII && (sHostIf == psc_pkg::HOST_IF_SGMII);

   // ===================================================
   // Sequencer
   psc_pkg::psc_state_t state_reg;
   psc_pkg::psc_state_t state_next;
   logic [CNT_W-1:0] settleCnt_reg;
   logic restartWr;
   logic latchNow;

   assign restartWr = regWrEn && (regAddr == psc_pkg::REG_RESTART)
                      && regWrData[psc_pkg::RESTART_BIT];
   // Straps are taken only once the pins have settled and passed the synchroniser
   assign latchNow = (state_reg == psc_pkg::PSC_SETTLE) && (settleCnt_reg == SETTLE_LAST);

   always_comb
   begin
      state_next = state_reg;
      unique case (state_reg)
         psc_pkg::PSC_SETTLE:
            if (latchNow)
               state_next = psc_pkg::PSC_RUN;
         psc_pkg::PSC_RUN:
            if (restartWr)
               state_next = psc_pkg::PSC_SETTLE;
      endcase
   end

   always_ff @(posedge clk)
   begin
      if (sys_rst || restartWr)
         settleCnt_reg <= '0;
      else if (state_reg == psc_pkg::PSC_SETTLE && !latchNow)
         settleCnt_reg <= settleCnt_reg + CNT_W'(1);
   end

   always_ff @(posedge clk)
   begin
      if (sys_rst)
         state_reg <= psc_pkg::PSC_SETTLE;
      else
         state_reg <= state_next;
   end

   // ===================================================
   // Latched straps, loaded only at the end of a settle window
   logic pol0_reg;
   logic pol6_reg;
   logic pol16_reg;

   always_ff @(posedge clk)
   begin
      if (sys_rst)
      begin
         mgmtAddressBits <= '0;
         hostInterfaceSelect <= '0;
         hostInterfaceReserved <= 1'b0;
         masterSlaveRole <= 1'b0;
         clockPinSelect <= 1'b0;
         pol0_reg <= 1'b0;
         pol6_reg <= 1'b0;
         pol16_reg <= 1'b0;
      end
      else if (latchNow)
      begin
         mgmtAddressBits <= addrDecoded;
         hostInterfaceSelect <= sHostIf;
         hostInterfaceReserved <= reservedCode;
         masterSlaveRole <= sPin0;
         clockPinSelect <= sRxD3;
         pol0_reg <= sPin0;
         pol6_reg <= sPin6;
         pol16_reg <= sPin16;
      end
   end

   // ===================================================
   // Registers
   logic linkHold_reg;
   logic [psc_pkg::REG_DATA_W-1:0] ledCfg_reg;
   logic wrLinkCtrl;
   logic wrLedCfg;

   assign wrLinkCtrl = regWrEn && (regAddr == psc_pkg::REG_LINK_CTRL);
   assign wrLedCfg = regWrEn && (regAddr == psc_pkg::REG_LED_CFG);

   // Hold bit is preset from the self-link strap and cleared by software
   always_ff @(posedge clk)
   begin
      if (sys_rst)
         linkHold_reg <= 1'b1;
      else if (latchNow)
         linkHold_reg <= managedStrap;
      else if (wrLinkCtrl)
         linkHold_reg <= regWrData[psc_pkg::LINK_HOLD_BIT];
   end

   always_ff @(posedge clk)
   begin
      if (sys_rst)
         ledCfg_reg <= psc_pkg::LED_CFG_RESET;
      else if (wrLedCfg)
         ledCfg_reg <= regWrData;
   end

   // Link start waits for the straps, then for the hold bit to drop
   always_ff @(posedge clk)
   begin
      if (sys_rst)
         linkStartEnable <= 1'b0;
      else
         linkStartEnable <= (state_next == psc_pkg::PSC_RUN) && !linkHold_reg
                            && !(latchNow && managedStrap);
   end

   always_ff @(posedge clk)
   begin
      if (sys_rst)
         strapsValid <= 1'b0;
      else
         strapsValid <= (state_next == psc_pkg::PSC_RUN);
   end

   // ===================================================
   // Read path; data stands one cycle after each read-enable cycle, else zero
   logic [psc_pkg::REG_DATA_W-1:0] statusWord;
   logic [psc_pkg::REG_DATA_W-1:0] linkCtrlWord;
   logic [psc_pkg::REG_DATA_W-1:0] rdMux;

   always_comb
   begin
      statusWord = '0;
      statusWord[psc_pkg::ST_ADDR_POS +: psc_pkg::ADDR_W] = mgmtAddressBits;
      statusWord[psc_pkg::ST_HOSTIF_POS +: 3] = hostInterfaceSelect;
      statusWord[psc_pkg::ST_ROLE_POS] = masterSlaveRole;
      statusWord[psc_pkg::ST_MANAGED_POS] = linkHold_reg;
      statusWord[psc_pkg::ST_CLKPIN_POS] = clockPinSelect;
      statusWord[psc_pkg::ST_POL0_POS] = pol0_reg;
      statusWord[psc_pkg::ST_POL6_POS] = pol6_reg;
      statusWord[psc_pkg::ST_POL16_POS] = pol16_reg;
      statusWord[psc_pkg::ST_RESERVED_POS] = hostInterfaceReserved;
      linkCtrlWord = '0;
      linkCtrlWord[psc_pkg::LINK_HOLD_BIT] = linkHold_reg;
   end

   assign rdMux = (regAddr == psc_pkg::REG_LINK_CTRL) ? linkCtrlWord :
                  (regAddr == psc_pkg::REG_LED_CFG) ? ledCfg_reg :
                  (regAddr == psc_pkg::REG_STRAP_STATUS) ? statusWord : '0;

   always_ff @(posedge clk)
   begin
      if (sys_rst || !regRdEn)
         regRdData <= '0;
      else
         regRdData <= rdMux;
   end

   // ===================================================
   // Indicator and clock pins
   logic [3:0] led0Sel;
   logic [3:0] led1Sel;
   logic [3:0] led2Sel;
   logic clkTog_reg;
   logic drive0;
   logic drive6;
   logic drive16;
   logic pinsActive;

   assign led0Sel = ledCfg_reg[psc_pkg::LED0_SEL_POS +: psc_pkg::LED_SEL_W];
   assign led1Sel = ledCfg_reg[psc_pkg::LED1_SEL_POS +: psc_pkg::LED_SEL_W];
   assign led2Sel = ledCfg_reg[psc_pkg::LED2_SEL_POS +: psc_pkg::LED_SEL_W];
   // Pins stay undriven while straps settle so the board resistors set the level
   assign pinsActive = (state_next == psc_pkg::PSC_RUN);

   assign drive0 = pinDrive(led0Sel, pol0_reg, linkUp, linkActivity, clkTog_reg);
   assign drive6 = clockPinSelect ?
                   pinDrive(led2Sel, pol6_reg, linkUp, linkActivity, clkTog_reg) :
                   pinDrive(led1Sel, pol6_reg, linkUp, linkActivity, clkTog_reg);
   assign drive16 = clockPinSelect ?
                    pinDrive(led1Sel, pol16_reg, linkUp, linkActivity, clkTog_reg) :
                    pinDrive(led2Sel, pol16_reg, linkUp, linkActivity, clkTog_reg);

   // Clock output runs at half the system clock
   always_ff @(posedge clk)
   begin
      if (sys_rst)
         clkTog_reg <= 1'b0;
      else
         clkTog_reg <= pinsActive && !clkTog_reg;
   end

   always_ff @(posedge clk)
   begin
      if (sys_rst)
      begin
         indicator0PinOut <= 1'b0;
         indicator1PinOut <= 1'b0;
         clockOutputPinOut <= 1'b0;
         indicator0PinOe <= 1'b0;
         indicator1PinOe <= 1'b0;
         clockOutputPinOe <= 1'b0;
      end
      else
      begin
         indicator0PinOut <= drive0;
         indicator1PinOut <= drive6;
         clockOutputPinOut <= drive16;
         indicator0PinOe <= pinsActive;
         indicator1PinOe <= pinsActive;
         clockOutputPinOe <= pinsActive;
      end
   end

endmodule

// ### tb/psc_strap_latch_properties.sv
module psc_strap_checker #(
   parameter bit HAS_SGMII = 1'b1
) (
   // Clock, reset, register port
   input wire logic clk,
   input wire logic sys_rst,
   input wire logic [15:0] regAddr,
   input wire logic [15:0] regWrData,
   input wire logic regWrEn,
   // Straps and pins
   input wire logic [1:0] rxCtrlStrap,
   input wire logic [1:0] rxErrorStrap,
   input wire logic [2:0] hostInterfaceStrap,
   input wire logic rxData3Strap,
   input wire logic indicator0PinIn,
   input wire logic indicator0PinOe,
   input wire logic indicator1PinOe,
   input wire logic clockOutputPinOe,
   // Latched configuration
   input wire logic [4:0] mgmtAddressBits,
   input wire logic [2:0] hostInterfaceSelect,
   input wire logic hostInterfaceReserved,
   input wire logic masterSlaveRole,
   input wire logic clockPinSelect,
   input wire logic linkStartEnable,
   input wire logic strapsValid
);
   timeunit 1ns;
   timeprecision 1ps;
   default clocking cb @(posedge clk);
   endclocking
   default disable iff (sys_rst);

   // ==========================================
   // Address decode, mode code 3 counts as mode 1
   function automatic logic [4:0] addrOf(input logic [1:0] c, input logic [1:0] e);
      return {1'b0, e == 2'h1 || e == 2'h2, c == 2'h1 || c == 2'h2, e == 2'h2, c == 2'h2};
   endfunction

   // ==========================================
   // Properties; the latch uses pin levels three edges before valid rises
   AST_ADDR_LATCH: assert property ($rose(strapsValid) |->
      mgmtAddressBits == addrOf($past(rxCtrlStrap, 3), $past(rxErrorStrap, 3)))
      else $error("address latched wrong");
   AST_HOSTIF_LATCH: assert property ($rose(strapsValid) |->
      hostInterfaceSelect == $past(hostInterfaceStrap, 3))
      else $error("host interface latched wrong");
   AST_RESERVED_CODE: assert property (strapsValid |-> hostInterfaceReserved ==
      (hostInterfaceSelect == 3'h0 && !HAS_SGMII))
      else $error("reserved flag wrong");
   AST_ROLE_LATCH: assert property ($rose(strapsValid) |->
      masterSlaveRole == $past(indicator0PinIn, 3))
      else $error("role latched wrong");
   AST_CLKPIN_LATCH: assert property ($rose(strapsValid) |->
      clockPinSelect == $past(rxData3Strap, 3))
      else $error("clock pin select latched wrong");
   AST_NO_EARLY_LINK: assert property (!strapsValid |-> !linkStartEnable)
      else $error("link start before latch");
   AST_RELEASE: assert property (strapsValid && regWrEn &&
      regAddr == psc_pkg::REG_LINK_CTRL && !regWrData[6] |-> ##2 linkStartEnable)
      else $error("link not released");
   AST_FROZEN: assert property (strapsValid && $past(strapsValid) |->
      $stable(mgmtAddressBits) && $stable(hostInterfaceSelect) &&
      $stable(masterSlaveRole) && $stable(clockPinSelect))
      else $error("latched values changed");
   AST_DRIVE: assert property (strapsValid |-> indicator0PinOe &&
      indicator1PinOe && clockOutputPinOe)
      else $error("indicator pin not driven");
endmodule

bind psc_strap_latch psc_strap_checker #(.HAS_SGMII(HAS_SGMII)) chk (.clk, .sys_rst,
   .regAddr, .regWrData, .regWrEn, .rxCtrlStrap, .rxErrorStrap, .hostInterfaceStrap,
   .rxData3Strap, .indicator0PinIn, .indicator0PinOe, .indicator1PinOe, .clockOutputPinOe,
   .mgmtAddressBits, .hostInterfaceSelect, .hostInterfaceReserved, .masterSlaveRole,
   .clockPinSelect, .linkStartEnable, .strapsValid);

// ### tb/psc_board_model.sv
module psc_board_model (
   // Strap resistor levels, order pin35, pin6, pin16
   input wire logic [2:0] pull,
   // Device side of the shared pins
   input wire logic [2:0] pinOut,
   input wire logic [2:0] pinOe,
   output logic [2:0] pinIn
);
   timeunit 1ns;
   timeprecision 1ps;
   // Undriven pin settles to its resistor; the system picks managed mode here
   assign pinIn = (pinOe & pinOut) | (~pinOe & pull);
endmodule

// ### tb/tb.sv
module tb;
   timeunit 1ns;
   timeprecision 1ps;
   localparam int SETTLE = 3;
   localparam logic [1:0] CM [9] = '{2'h0, 2'h1, 2'h2, 2'h0, 2'h0, 2'h1, 2'h2, 2'h1, 2'h2};
   localparam logic [1:0] EM [9] = '{2'h0, 2'h0, 2'h0, 2'h1, 2'h2, 2'h1, 2'h1, 2'h2, 2'h2};
   localparam logic [4:0] ADDR [9] = '{5'h0, 5'h4, 5'h5, 5'h8, 5'ha, 5'hc, 5'hd, 5'he, 5'hf};
   localparam logic [15:0] LCFG [4] = '{16'h0333, 16'h0444, 16'h0000, 16'h0111};
   logic clk = 1'b0;
   logic sys_rst = 1'b1;
   logic [15:0] regAddr = 16'h0000;
   logic [15:0] regWrData = 16'h0000;
   logic regWrEn = 1'b0;
   logic regRdEn = 1'b0;
   logic [15:0] regRdData;
   logic [1:0] rxCtrlStrap = 2'h0;
   logic [1:0] rxErrorStrap = 2'h0;
   logic [2:0] hostInterfaceStrap = 3'h0;
   logic rxData3Strap = 1'b0;
   logic [2:0] pull = 3'h0;
   logic [2:0] pinIn;
   logic [2:0] pinOut;
   logic [2:0] pinOe;
   logic linkUp = 1'b0;
   logic linkActivity = 1'b0;
   logic [4:0] mgmtAddressBits;
   logic [2:0] hostInterfaceSelect;
   logic hostInterfaceReserved, masterSlaveRole, clockPinSelect, linkStartEnable, strapsValid;
   logic reservedAlt;
   int n_errors = 0;
   int tests_run = 0;
   int cycles = 0;

   psc_board_model board (.pull(pull), .pinOut(pinOut), .pinOe(pinOe), .pinIn(pinIn));
   psc_strap_latch #(.HAS_SGMII(1'b1), .SETTLE_CYCLES(SETTLE)) dut (.clk(clk),
      .sys_rst(sys_rst), .regAddr(regAddr), .regWrData(regWrData), .regWrEn(regWrEn),
      .regRdEn(regRdEn), .regRdData(regRdData), .rxCtrlStrap(rxCtrlStrap),
      .rxErrorStrap(rxErrorStrap), .hostInterfaceStrap(hostInterfaceStrap),
      .rxData3Strap(rxData3Strap), .indicator0PinIn(pinIn[0]), .indicator0PinOut(pinOut[0]),
      .indicator0PinOe(pinOe[0]), .indicator1PinIn(pinIn[1]), .indicator1PinOut(pinOut[1]),
      .indicator1PinOe(pinOe[1]), .clockOutputPinIn(pinIn[2]), .clockOutputPinOut(pinOut[2]),
      .clockOutputPinOe(pinOe[2]), .linkUp(linkUp), .linkActivity(linkActivity),
      .mgmtAddressBits(mgmtAddressBits), .hostInterfaceSelect(hostInterfaceSelect),
      .hostInterfaceReserved(hostInterfaceReserved), .masterSlaveRole(masterSlaveRole),
      .clockPinSelect(clockPinSelect), .linkStartEnable(linkStartEnable),
      .strapsValid(strapsValid));
   // Variant without the serial interface, watched only for its reserved flag
   psc_strap_latch #(.HAS_SGMII(1'b0), .SETTLE_CYCLES(SETTLE)) dutNoSgmii (.clk(clk),
      .sys_rst(sys_rst), .regAddr(regAddr), .regWrData(regWrData), .regWrEn(regWrEn),
      .regRdEn(regRdEn), .regRdData(), .rxCtrlStrap(rxCtrlStrap),
      .rxErrorStrap(rxErrorStrap), .hostInterfaceStrap(hostInterfaceStrap),
      .rxData3Strap(rxData3Strap), .indicator0PinIn(pinIn[0]), .indicator0PinOut(),
      .indicator0PinOe(), .indicator1PinIn(pinIn[1]), .indicator1PinOut(),
      .indicator1PinOe(), .clockOutputPinIn(pinIn[2]), .clockOutputPinOut(),
      .clockOutputPinOe(), .linkUp(linkUp), .linkActivity(linkActivity),
      .mgmtAddressBits(), .hostInterfaceSelect(), .hostInterfaceReserved(reservedAlt),
      .masterSlaveRole(), .clockPinSelect(), .linkStartEnable(), .strapsValid());

   // ==========================================
   // Shared tasks
   task automatic chk(input string what, input logic [15:0] seen, input logic [15:0] exp);
      tests_run++;
      if (seen !== exp)
      begin
         n_errors++;
         $display("wrong value %s expected %h seen %h", what, exp, seen);
      end
   endtask

   task automatic wr(input logic [15:0] a, input logic [15:0] d);
      @(posedge clk);
      regAddr <= a;
      regWrData <= d;
      regWrEn <= 1'b1;
      @(posedge clk);
      regWrEn <= 1'b0;
   endtask

   task automatic rd(input logic [15:0] a, output logic [15:0] d);
      @(posedge clk);
      regAddr <= a;
      regRdEn <= 1'b1;
      @(posedge clk);
      regRdEn <= 1'b0;
      #1;
      d = regRdData;
   endtask

   // Straps are held from reset through latch; the sync flops need the margin
   task automatic boot(input logic [1:0] c, input logic [1:0] e, input logic [2:0] h,
         input logic d3, input logic [2:0] pl);
      int k;
      @(posedge clk);
      sys_rst <= 1'b1;
      rxCtrlStrap <= c;
      rxErrorStrap <= e;
      hostInterfaceStrap <= h;
      rxData3Strap <= d3;
      pull <= pl;
      repeat (2) @(posedge clk);
      #1;
      chk("outputs in reset", {12'h000, pinOe, strapsValid}, 16'h0000);
      @(posedge clk);
      sys_rst <= 1'b0;
      k = 0;
      while (strapsValid !== 1'b1 && k < 20)
      begin
         @(posedge clk);
         #1;
         k++;
      end
      chk("straps latched", 16'(strapsValid), 16'h0001);
   endtask

   // ==========================================
   // Scenarios
   task automatic t_straps();
      logic [15:0] v;
      logic [2:0] pl;
      logic [2:0] lv;
      logic managed;
      for (int i = 0; i < 9; i++)
      begin
         pl = {~i[2], i[2], i[0]};
         boot(CM[i], EM[i], i[2:0], i[1], pl);
         managed = i[1] ? pl[2] : pl[1];
         if (i == 0)
            chk("default address", 16'(mgmtAddressBits), 16'h0000);
         chk("address", 16'(mgmtAddressBits), 16'(ADDR[i]));
         rd(psc_pkg::REG_STRAP_STATUS, v);
         chk("status address", 16'(v[4:0]), 16'(ADDR[i]));
         chk("host interface", 16'(hostInterfaceSelect), 16'(i[2:0]));
         chk("reserved code", 16'(hostInterfaceReserved), 16'h0000);
         chk("reserved code no sgmii", 16'(reservedAlt), 16'(i[2:0] == 3'h0));
         chk("role", 16'(masterSlaveRole), 16'(i[0]));
         chk("clock pin select", 16'(clockPinSelect), 16'(i[1]));
         chk("link start", 16'(linkStartEnable), 16'(!managed));
         rd(psc_pkg::REG_LED_CFG, v);
         chk("indicator cfg reset", v, psc_pkg::LED_CFG_RESET);
         for (int j = 0; j < 4; j++)
         begin
            @(posedge clk);
            linkUp <= (j == 2);
            linkActivity <= (j == 3);
            wr(psc_pkg::REG_LED_CFG, LCFG[j]);
            rd(psc_pkg::REG_LED_CFG, v);
            chk("indicator cfg", v, LCFG[j]);
            repeat (2) @(posedge clk);
            #1;
            lv = (j == 0) ? pl : ~pl;
            chk("indicator levels", 16'(pinOut), 16'(lv));
         end
         rd(psc_pkg::REG_LINK_CTRL, v);
         chk("hold bit", v, {9'h000, managed, 6'h00});
         wr(psc_pkg::REG_LINK_CTRL, 16'h0000);
         // Link start follows the hold bit one flop later
         @(posedge clk);
         #1;
         chk("link released", 16'(linkStartEnable), 16'h0001);
      end
      $display("test straps done");
   endtask

   task automatic t_frozen();
      logic [15:0] snap;
      logic [15:0] v;
      boot(2'h2, 2'h2, 3'h5, 1'b1, 3'h0);
      rd(psc_pkg::REG_STRAP_STATUS, snap);
      @(posedge clk);
      rxCtrlStrap <= 2'h0;
      rxErrorStrap <= 2'h1;
      hostInterfaceStrap <= 3'h2;
      rxData3Strap <= 1'b0;
      pull <= 3'h7;
      wr(psc_pkg::REG_STRAP_STATUS, 16'h0000);
      repeat (10) @(posedge clk);
      rd(psc_pkg::REG_STRAP_STATUS, v);
      chk("frozen status", v, snap);
      chk("frozen address", 16'(mgmtAddressBits), 16'h000f);
      chk("frozen host interface", 16'(hostInterfaceSelect), 16'h0005);
      rd(16'h0123, v);
      chk("unmapped read", v, 16'h0000);
      // Software restart releases the pins, so the new latch sees the resistors
      wr(psc_pkg::REG_RESTART, 16'h8000);
      #1;
      chk("restart drops valid", 16'(strapsValid), 16'h0000);
      repeat (SETTLE) @(posedge clk);
      #1;
      chk("restart relatched", 16'(strapsValid), 16'h0001);
      chk("restart address", 16'(mgmtAddressBits), 16'h0008);
      chk("restart host interface", 16'(hostInterfaceSelect), 16'h0002);
      chk("restart role", 16'(masterSlaveRole), 16'h0001);
      chk("restart clock pin select", 16'(clockPinSelect), 16'h0000);
      $display("test frozen done");
   endtask

   task automatic report_and_stop();
      $display("checks %0d mismatches %0d", tests_run, n_errors);
      if (n_errors == 0 && tests_run > 0)
         $display("Simulation passed");
      else
         $display("Simulation failed");
      $finish;
   endtask

   // ==========================================
   // Clock, hang guard, main sequence
   initial
   begin
      forever #12.5 clk = ~clk;
   end

   always @(posedge clk)
   begin
      cycles <= cycles + 1;
      if (cycles == 20000)
      begin
         n_errors++;
         report_and_stop();
      end
   end

   initial
   begin
      repeat (10) @(posedge clk);
      sys_rst <= 1'b0;
      t_straps();
      t_frozen();
      report_and_stop();
   end
endmodule
